//--- dma_channel_control_bits.sv
// per-channel burst-only, request-mask, enable and descriptor-select bits,
// with an axi4-lite slave, request gating and an event interrupt.
// assumes request lines come from other clock domains; engine events are
// one-cycle pulses on aclk.
`timescale 1ns/1ns
`default_nettype none
module dma_channel_control_bits
  import dma_bits_pkg::*;
#(
  parameter int channels = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral request pins, asynchronous
  input wire logic [channels-1:0] burst_request,
  input wire logic [channels-1:0] single_request,
  // engine events, one-cycle pulses per channel
  input wire logic [channels-1:0] cycle_done,
  input wire logic [channels-1:0] short_remainder,
  input wire logic [channels-1:0] alt_cycle_next_burst,
  input wire logic [channels-1:0] stop_code_fetched,
  input wire logic [channels-1:0] bus_error,
  input wire logic [channels-1:0] descriptor_toggle,
  input wire logic [2:0] fetched_cycle_type,
  // gated requests to the arbiter
  output logic [channels-1:0] burst_request_out,
  output logic [channels-1:0] single_request_out,
  // current bit state for the engine
  output logic [channels-1:0] burst_only,
  output logic [channels-1:0] channel_on,
  output logic [channels-1:0] use_alternate,
  output logic irq
);

  // elaboration check on the channel count
  if (channels < 1 || channels > 32)
  begin : g_bad_channels
    $error("channels must lie between 1 and 32");
  end

  // all state of the block lives in one packed struct. the combinational
  // process builds next_state from state and the inputs, and a single
  // clocked process registers it. this keeps the reset in one place and
  // makes it plain that every output comes from a register field.
  //
  // the fields fall into five groups:
  //   write slave: holding slots for address and data, and the response
  //   read slave: the pending answer with its data and response code
  //   request path: two synchroniser stages per pin and the gated output
  //   channel bits: the four shared set/clear state vectors
  //   interrupt: sticky event status, its enable and the level output
  typedef struct packed {
    // write address slot; full from the edge it is taken until the write
    logic aw_held;
    logic [addr_width-1:0] aw_addr;
    // write data slot and its byte strobes, filled independently of the address
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // write response, standing until the master takes it
    logic bvalid;
    logic [1:0] bresp;
    // read answer, standing until the master takes it
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // request pin synchronisers; only the second stage feeds logic
    logic [channels-1:0] burst_sync1;
    logic [channels-1:0] burst_sync2;
    logic [channels-1:0] single_sync1;
    logic [channels-1:0] single_sync2;
    // gated request levels towards the arbiter
    logic [channels-1:0] burst_out;
    logic [channels-1:0] single_out;
    // burst-only selection per channel
    logic [channels-1:0] burst_only;
    // external request mask per channel, 1 masks both lines
    logic [channels-1:0] mask;
    // channel enable per channel
    logic [channels-1:0] on;
    // descriptor select per channel, 1 means alternate
    logic [channels-1:0] alt;
    // sticky event bits, their enables and the registered level
    logic [irq_width-1:0] irq_status;
    logic [irq_width-1:0] irq_enable;
    logic irq;
  } state_t;

  state_t state;
  state_t next_state;

  // mask of implemented channel positions, wide enough for the bus word
  localparam logic [31:0] chan_mask = 32'hffff_ffff >> (32 - channels);
  localparam logic [count_width-1:0] count_less_one = count_width'(channels - 1);

  // byte strobes expanded into a bit mask
  function automatic logic [31:0] strobe_bits(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // whether an offset names a mapped register
  function automatic logic mapped(input logic [addr_width-1:0] a);
    return a[1:0] == 2'h0 && a <= off_irq_clear;
  endfunction

  // channel-wide write vector for one register, limited to real channels
  function automatic logic [channels-1:0] hit(input logic [addr_width-1:0] a,
                                              input logic [addr_width-1:0] off,
                                              input logic [31:0] bits);
    logic [31:0] v;
    v = (a == off) ? (bits & chan_mask) : reset_word;
    return v[channels-1:0];
  endfunction

  logic do_write;
  logic [31:0] wbits;
  // per-register write vectors, already limited to implemented channels
  logic [channels-1:0] w_bset;
  logic [channels-1:0] w_bclr;
  logic [channels-1:0] w_mset;
  logic [channels-1:0] w_mclr;
  logic [channels-1:0] w_oset;
  logic [channels-1:0] w_oclr;
  logic [channels-1:0] w_aset;
  logic [channels-1:0] w_aclr;
  // engine-driven updates for this cycle
  logic [channels-1:0] stop_now;
  logic [channels-1:0] off_now;
  logic [channels-1:0] burst_clear_now;
  logic [channels-1:0] burst_set_now;
  logic [31:0] rword;
  logic [irq_width-1:0] events;

  // write slave behaviour:
  //   the address and data channels each have a one-deep holding slot.
  //   a slot fills on the edge at which its valid is seen with the slot
  //   empty, so the master may offer them in either order or together.
  //   once both slots are full and no response stands, the write is
  //   applied in one cycle, both slots empty and bvalid rises.
  //   bvalid then stands until bready is seen high.
  //   a new address may be taken while the response still stands, but
  //   it is not applied until that response has been taken.
  // hazard: the slots do not check the response channel before filling,
  // so a master that ignores bvalid cannot lose a write, only stall.
  //
  // read slave behaviour:
  //   a read is taken when arvalid is seen with no answer pending; the
  //   answer rises on the next edge and stands until rready is seen.
  //   only one read is in flight, which is all the master may issue.
  //
  // channel bit behaviour:
  //   set and clear registers of one pair act on one shared vector.
  //   software is applied first and the engine's update on top of it,
  //   so that a same-cycle engine event always decides the bit.
  //   a software set and clear of one bit in one cycle cannot happen,
  //   since only one write is applied per cycle.
  //
  // request path:
  //   pins are treated as asynchronous and pass two flip-flops; the gate
  //   adds one more stage, so a pin change shows three edges later.
  //   the gate reads the registered mask and burst-only bits, so a
  //   software write takes effect on the request outputs one edge after
  //   the bit itself changes.
  //
  // interrupt:
  //   the three engine events are ored over all channels into sticky
  //   bits. a clear write and a new event in one cycle leave the bit set.
  //   the level output is registered from the next status and enable.
  always_comb
  begin
    next_state = state;
    do_write = 1'b0;
    wbits = '0;
    rword = reset_word;
    // address and data may arrive in either order; each is held until both are in
    if (s_axi_awvalid && !state.aw_held)
    begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_held)
    begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (state.aw_held && state.w_held && !state.bvalid)
    begin
      do_write = 1'b1;
      wbits = state.w_data & strobe_bits(state.w_strb);
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = mapped(state.aw_addr) ? resp_okay : resp_slverr;
    end
    if (state.bvalid && s_axi_bready)
    begin
      next_state.bvalid = 1'b0;
    end
    w_bset = do_write ? hit(state.aw_addr, off_burst_set, wbits) : '0;
    w_bclr = do_write ? hit(state.aw_addr, off_burst_clear, wbits) : '0;
    w_mset = do_write ? hit(state.aw_addr, off_mask_set, wbits) : '0;
    w_mclr = do_write ? hit(state.aw_addr, off_mask_clear, wbits) : '0;
    w_oset = do_write ? hit(state.aw_addr, off_on_set, wbits) : '0;
    w_oclr = do_write ? hit(state.aw_addr, off_on_clear, wbits) : '0;
    w_aset = do_write ? hit(state.aw_addr, off_desc_set, wbits) : '0;
    w_aclr = do_write ? hit(state.aw_addr, off_desc_clear, wbits) : '0;

    // software first, engine afterwards so the engine's update wins
    next_state.burst_only = (state.burst_only | w_bset) & ~w_bclr;
    next_state.mask = (state.mask | w_mset) & ~w_mclr;
    next_state.on = (state.on | w_oset) & ~w_oclr;
    next_state.alt = (state.alt | w_aset) & ~w_aclr;
    // short remainder after the next-to-last burst drops burst-only, unless alt_cycle_next_burst sets it in the same cycle
    // the engine raises short_remainder only after the next-to-last burst
    burst_clear_now = short_remainder;
    burst_set_now = alt_cycle_next_burst;
    next_state.burst_only = (next_state.burst_only & ~burst_clear_now) | burst_set_now;
    stop_now = (fetched_cycle_type == cycle_stop) ? stop_code_fetched : '0;
    off_now = cycle_done | stop_now | bus_error;
    next_state.on = next_state.on & ~off_now;
    // engine toggles from the current bit, ignoring a same-cycle write
    next_state.alt = (next_state.alt & ~descriptor_toggle) |
                     ((state.alt ^ descriptor_toggle) & descriptor_toggle);

    // interrupt events; set beats a same-cycle clear
    events = '0;
    events[irq_done] = |cycle_done;
    events[irq_stop] = |stop_now;
    events[irq_error] = |bus_error;
    if (do_write && state.aw_addr == off_irq_enable)
    begin
      next_state.irq_enable = wbits[irq_width-1:0];
    end
    if (do_write && state.aw_addr == off_irq_clear)
    begin
      next_state.irq_status = state.irq_status & ~wbits[irq_width-1:0];
    end
    next_state.irq_status = next_state.irq_status | events;
    next_state.irq = |(next_state.irq_status & next_state.irq_enable);

    // read path: one request at a time, answered the cycle after it is taken
    if (s_axi_arvalid && !state.rvalid)
    begin
      unique case (s_axi_araddr)
        off_burst_set: rword[channels-1:0] = state.burst_only;
        off_mask_set: rword[channels-1:0] = state.mask;
        off_on_set: rword[channels-1:0] = state.on;
        off_desc_set: rword[channels-1:0] = state.alt;
        off_status: rword[count_lsb +: count_width] = count_less_one;
        off_irq_status: rword[irq_width-1:0] = state.irq_status;
        off_irq_enable: rword[irq_width-1:0] = state.irq_enable;
        default: rword = reset_word; // write-only registers read zero
      endcase
      next_state.rvalid = 1'b1;
      next_state.rdata = rword;
      next_state.rresp = mapped(s_axi_araddr) ? resp_okay : resp_slverr;
    end
    else if (state.rvalid && s_axi_rready)
    begin
      next_state.rvalid = 1'b0;
    end

    // request gating from synchronised pins
    next_state.burst_sync1 = burst_request;
    next_state.burst_sync2 = state.burst_sync1;
    next_state.single_sync1 = single_request;
    next_state.single_sync2 = state.single_sync1;
    next_state.burst_out = state.burst_sync2 & ~state.mask;
    next_state.single_out = state.single_sync2 & ~state.mask & ~state.burst_only;
  end

  // one register stage for the whole block
  // reset is synchronous: every field, including the synchronisers, goes
  // to zero, so no request and no interrupt can show right after release.
  // the ready outputs are the inverse of full slots and so read high
  // during reset; a master must still wait for aresetn before offering.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // outputs straight from state fields
  // limitation: the readys are inverted slot flags rather than flops of
  // their own; they still change only on the clock edge.
  assign s_axi_awready = !state.aw_held;
  assign s_axi_wready = !state.w_held;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign burst_request_out = state.burst_out;
  assign single_request_out = state.single_out;
  assign burst_only = state.burst_only;
  assign channel_on = state.on;
  assign use_alternate = state.alt;
  assign irq = state.irq;

endmodule // dma_channel_control_bits
`default_nettype wire

//--- dma_bits_pkg.sv
// constants for the dma channel control bit bank
// assumes a 32-bit axi4-lite register bus and one 100 MHz clock
package dma_bits_pkg;
  localparam int addr_width = 12;
  // register byte offsets
  localparam logic [11:0] off_burst_set = 12'h000;
  localparam logic [11:0] off_burst_clear = 12'h004;
  localparam logic [11:0] off_mask_set = 12'h008;
  localparam logic [11:0] off_mask_clear = 12'h00c;
  localparam logic [11:0] off_on_set = 12'h010;
  localparam logic [11:0] off_on_clear = 12'h014;
  localparam logic [11:0] off_desc_set = 12'h018;
  localparam logic [11:0] off_desc_clear = 12'h01c;
  localparam logic [11:0] off_status = 12'h020;
  localparam logic [11:0] off_irq_status = 12'h024;
  localparam logic [11:0] off_irq_enable = 12'h028;
  localparam logic [11:0] off_irq_clear = 12'h02c;
  // status field position of channel count less one
  localparam int count_lsb = 16;
  localparam int count_width = 5;
  // interrupt event bits
  localparam int irq_done = 0;
  localparam int irq_stop = 1;
  localparam int irq_error = 2;
  localparam int irq_width = 3;
  // descriptor cycle type that stops a channel
  localparam logic [2:0] cycle_stop = 3'h0;
  // axi response codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam logic [31:0] reset_word = 32'h0000_0000;
endpackage

//--- dma_bits_monitor.sv
// checker for the dma channel control bit bank, bound to its top module
// assumes one-cycle engine pulses and pins seen on the outputs 3 edges on
`timescale 1ns/1ns
`default_nettype none
module dma_bits_monitor
  import dma_bits_pkg::*;
#(
  parameter int channels = 32
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [channels-1:0] burst_request,
  input wire logic [channels-1:0] burst_request_out,
  input wire logic [channels-1:0] single_request_out,
  input wire logic [channels-1:0] burst_only,
  input wire logic [channels-1:0] channel_on,
  input wire logic [channels-1:0] use_alternate,
  input wire logic [channels-1:0] cycle_done,
  input wire logic [channels-1:0] short_remainder,
  input wire logic [channels-1:0] alt_cycle_next_burst,
  input wire logic [channels-1:0] stop_code_fetched,
  input wire logic [channels-1:0] bus_error,
  input wire logic [channels-1:0] descriptor_toggle,
  input wire logic [2:0] fetched_cycle_type
);
  // channel 0 only; every channel shares the same logic
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_burst_pin_cause: assert property (burst_request_out[0] |-> $past(burst_request[0], 3))
    else $error("burst out without pin");
  a_single_gated: assert property (burst_only[0] && $past(burst_only[0]) |-> !single_request_out[0])
    else $error("single out while burst-only");
  a_done_off: assert property (cycle_done[0] |=> !channel_on[0])
    else $error("channel on after done");
  a_error_off: assert property (bus_error[0] |=> !channel_on[0])
    else $error("channel on after error");
  a_stop_off: assert property (stop_code_fetched[0] && fetched_cycle_type == cycle_stop |=> !channel_on[0])
    else $error("channel on after stop");
  a_short_clears: assert property (short_remainder[0] |=> !burst_only[0])
    else $error("burst-only kept");
  a_next_burst_sets: assert property (alt_cycle_next_burst[0] && !short_remainder[0] |=> burst_only[0])
    else $error("burst-only not set");
  a_desc_toggles: assert property (descriptor_toggle[0] |=> use_alternate[0] != $past(use_alternate[0]))
    else $error("select not toggled");
  c_gated: cover property (burst_only[0] && burst_request_out[0]);
  c_done: cover property (cycle_done[0]);
  c_toggle: cover property (descriptor_toggle[0]);
endmodule // dma_bits_monitor
bind dma_channel_control_bits dma_bits_monitor #(.channels(channels)) dma_bits_monitor_inst (
  .aclk, .aresetn, .burst_request, .burst_request_out, .single_request_out, .burst_only,
  .channel_on, .use_alternate, .cycle_done, .short_remainder, .alt_cycle_next_burst,
  .stop_code_fetched, .bus_error, .descriptor_toggle, .fetched_cycle_type);
`default_nettype wire

//--- dma_peripheral_model.sv
// peripheral model: drives burst and single request levels per channel
// assumes the bench names the wanted levels and a lag in aclk cycles
`timescale 1ns/1ns
`default_nettype none
module dma_peripheral_model
#(
  parameter int channels = 4
)
(
  input wire logic aclk,
  input wire logic [3:0] lag,
  input wire logic [channels-1:0] want_burst,
  input wire logic [channels-1:0] want_single,
  output logic [channels-1:0] burst_request = '0,
  output logic [channels-1:0] single_request = '0
);
  logic [3:0] count = 4'h0;
  // a slow peripheral waits lag cycles before moving its lines; it follows
  // want_burst and want_single and knows nothing of burst-only
  always @(posedge aclk)
    if (count < lag && {want_burst, want_single} != {burst_request, single_request})
      count <= count + 4'h1;
    else
    begin
      count <= 4'h0;
      burst_request <= want_burst;
      single_request <= want_single;
    end
endmodule // dma_peripheral_model
`default_nettype wire

//--- test_dma_channel_control_bits.sv
// self-checking bench for the dma channel control bit bank, four channels
// assumes the peripheral model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_dma_channel_control_bits;
  import dma_bits_pkg::*;
  localparam int ch = 4;
  logic aclk = 1'b0, aresetn = 1'b0, irq, got;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_data;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [ch-1:0] want_b = '0, want_s = '0, breq, sreq, bout, sout, bo, on, alt;
  logic [ch-1:0] ev [6] = '{default: '0};
  logic [3:0] lag = 4'h0;
  logic [2:0] ctype = 3'h0;
  int fail_count = 0;
  int compares = 0;
  dma_channel_control_bits #(.channels(ch)) dma_channel_control_bits_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .burst_request(breq), .single_request(sreq), .cycle_done(ev[0]), .short_remainder(ev[1]),
    .alt_cycle_next_burst(ev[2]), .stop_code_fetched(ev[3]), .bus_error(ev[4]),
    .descriptor_toggle(ev[5]), .fetched_cycle_type(ctype), .burst_request_out(bout),
    .single_request_out(sout), .burst_only(bo), .channel_on(on), .use_alternate(alt), .irq);
  dma_peripheral_model #(.channels(ch)) dma_peripheral_model_inst (.aclk, .lag,
    .want_burst(want_b), .want_single(want_s), .burst_request(breq), .single_request(sreq));
  initial forever #5 aclk = ~aclk;
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // bus write: address and data dropped as each is taken, then the response
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    got = 1'b0;
    while (!got)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      got = s_axi_bvalid;
      resp = s_axi_bresp;
      s_axi_bready <= !got;
    end
  endtask
  // bus read and compare; rready held until the data is seen
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    got = 1'b0;
    while (!got)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      got = s_axi_rvalid;
      rd_data = s_axi_rdata;
      s_axi_rready <= !got;
    end
    chk(n, e, rd_data);
  endtask
  // one-cycle engine event on the channels in m
  task automatic pulse(input int k, input logic [ch-1:0] m);
    @(posedge aclk);
    ev[k] <= m;
    @(posedge aclk);
    ev[k] <= '0;
  endtask
  // each set/clear pair; bits above channel 3 must stay dead
  task automatic t_regs;
    rc("count", off_status, 32'(ch - 1) << count_lsb);
    for (int k = 0; k < 4; k++)
    begin
      rc("reset", 12'(8 * k), 32'h0);
      wr(12'(8 * k), 32'hffff_ffff);
      rc("set", 12'(8 * k), 32'hf);
      wr(12'(8 * k + 4), 32'h5);
      wr(12'(8 * k), 32'h0);
      rc("clear", 12'(8 * k), 32'ha);
      rc("write-only", 12'(8 * k + 4), 32'h0);
      wr(12'(8 * k + 4), 32'hffff_ffff);
    end
    wr(12'h030, 32'h1);
    chk("unmapped", 32'(resp_slverr), 32'(resp));
  endtask
  // burst-only on channel 0, mask toggled on channel 1, slow peripheral
  task automatic t_requests;
    wr(off_burst_set, 32'h1);
    lag <= 4'h3;
    want_b <= 4'h3;
    want_s <= 4'h3;
    repeat (10) @(posedge aclk);
    chk("requests", 32'h32, 32'({bout, sout}));
    wr(off_mask_set, 32'h2);
    repeat (4) @(posedge aclk);
    chk("masked", 32'h10, 32'({bout, sout}));
    wr(off_mask_clear, 32'h2);
    repeat (4) @(posedge aclk);
    chk("unmasked", 32'h32, 32'({bout, sout}));
    want_b <= '0;
    want_s <= '0;
  endtask
  // engine updates of enable, burst-only and descriptor select
  task automatic t_engine;
    wr(off_on_set, 32'hf);
    wr(off_burst_set, 32'hf);
    pulse(0, 4'h1);
    pulse(4, 4'h2);
    pulse(3, 4'h4);
    ctype <= 3'h1;
    pulse(3, 4'h8);
    ctype <= 3'h0;
    rc("enable", off_on_set, 32'h8);
    pulse(1, 4'h3);
    pulse(2, 4'h1);
    rc("burst-only", off_burst_set, 32'hd);
    pulse(5, 4'h3);
    pulse(5, 4'h1);
    rc("select", off_desc_set, 32'h2);
  endtask
  // interrupt raised, masked, then cleared
  task automatic t_irq;
    wr(off_irq_clear, 32'h7);
    rc("irq empty", off_irq_status, 32'h0);
    wr(off_irq_enable, 32'h7);
    pulse(0, 4'h1);
    rc("irq status", off_irq_status, 32'h1);
    chk("irq high", 32'h1, 32'(irq));
    wr(off_irq_enable, 32'h0);
    wr(off_irq_clear, 32'h7);
    rc("irq cleared", off_irq_status, 32'h0);
    chk("irq low", 32'h0, 32'(irq));
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_requests;
    t_engine;
    t_irq;
    give_verdict;
  end
  // watchdog: far beyond the few hundred cycles the run needs
  initial
  begin
    #200000;
    fail_count++;
    give_verdict;
  end
endmodule // test_dma_channel_control_bits
`default_nettype wire
